// ### design/chan_mute_drv.sv
// Output channel leg control under mute for differential and single-ended drivers
`timescale 1ns/100ps
`default_nettype none
module chan_mute_drv (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic mute_on,
  input wire logic [1:0] muted_drive_sel,
  input wire logic single_ended,
  // Clock source legs
  input wire logic src_p,
  input wire logic src_n,
  // Driver
  output logic out_p,
  output logic out_n,
  output clkgen_regs_pkg::leg_drive_type p_drive,
  output clkgen_regs_pkg::leg_drive_type n_drive
);
  import clkgen_regs_pkg::*;

  leg_drive_type p_next;
  leg_drive_type n_next;

  function automatic logic leg_level(input leg_drive_type drive, input logic src);
    case (drive)
      LEG_NORMAL: return src;
      LEG_HIGH, LEG_RAIL: return 1'h1;
      default: return 1'h0;
    endcase
  endfunction

  always_comb begin
    p_next = LEG_NORMAL;
    n_next = LEG_NORMAL;
    if (mute_on) begin
      case (muted_drive_sel)
        MUTE_LVL_SOFT: begin
          p_next = single_ended ? LEG_NORMAL : LEG_VCM;
          n_next = single_ended ? LEG_LOW : LEG_VCM;
        end
        MUTE_LVL_HIGH: begin
          p_next = single_ended ? LEG_LOW : LEG_HIGH;
          n_next = single_ended ? LEG_NORMAL : LEG_LOW;
        end
        MUTE_LVL_RAIL: begin
          p_next = single_ended ? LEG_LOW : LEG_RAIL;
          n_next = LEG_LOW;
        end
        default: begin
          p_next = LEG_NORMAL;
          n_next = LEG_NORMAL;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      p_drive <= LEG_NORMAL;
      n_drive <= LEG_NORMAL;
    end else begin
      p_drive <= p_next;
      n_drive <= n_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_p <= 1'h0;
      out_n <= 1'h0;
    end else begin
      out_p <= leg_level(p_next, src_p);
      out_n <= leg_level(n_next, src_n);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_unmuted_normal: assert property (
    nrst && !mute_on |=> (p_drive == LEG_NORMAL) && (n_drive == LEG_NORMAL) &&
      (out_p == $past(src_p)))
    else $error("unmuted channel not running normally");
  a_bypass_legs: assert property (
    mute_on && (muted_drive_sel == MUTE_LVL_BYPASS) |=> (p_drive == LEG_NORMAL) && (n_drive == LEG_NORMAL))
    else $error("bypass code still muting");
  a_code1_legs: assert property (
    mute_on && (muted_drive_sel == MUTE_LVL_SOFT) |=> $past(single_ended) ?
      (p_drive == LEG_NORMAL) && (n_drive == LEG_LOW) && !out_n :
      (p_drive == LEG_VCM) && (n_drive == LEG_VCM))
    else $error("code 1 legs wrong");
  a_code2_legs: assert property (
    mute_on && (muted_drive_sel == MUTE_LVL_HIGH) |=> $past(single_ended) ?
      (p_drive == LEG_LOW) && (n_drive == LEG_NORMAL) && !out_p :
      (p_drive == LEG_HIGH) && out_p && !out_n)
    else $error("code 2 legs wrong");
  a_code3_legs: assert property (
    mute_on && (muted_drive_sel == MUTE_LVL_RAIL) |=> (n_drive == LEG_LOW) &&
      (p_drive == ($past(single_ended) ? LEG_LOW : LEG_RAIL)))
    else $error("code 3 legs wrong");
endmodule // chan_mute_drv
`default_nettype wire

// ### design/clkgen_regs_pkg.sv
// Package: register map, fields and encodings of the reference status and mute block
// Function
// - Status register bit 7 shows the secondary input rising-valid flag, read-only, reset 0.
// - Status register bit 6 shows the secondary input falling-valid flag, read-only, reset 0.
// - Status register bits 5 and 4 show primary rising and falling valid, read-only, reset 0.
// - Pin control bit 1 set makes status pin B open drain, cleared gives push-pull, reset 0.
// - Pin control bit 0 set makes status pin A open drain, read-write, reset 0.
// - Pin control bits 5 and 4 turn on spike limiting for status pins B and A.
// - Mute level bits 7 to 6 hold the channel 3 muted drive code, read-write, reset 1.
// - Code 0 bypasses muting; code 1 gives common mode, or P normal and N low single-ended.
// - Code 2 forces high, or P low and N normal; code 3 gives P rail N ground, or both low.
// - The code only shapes the muted drive; the separate mute bit decides muting.
`default_nettype none
package clkgen_regs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  // Register indices; the byte address is four times the index
  localparam logic [5:0] IDX_SLEW_STATUS = 6'h12;
  localparam logic [5:0] IDX_STAT_PIN_CTL = 6'h13;
  localparam logic [5:0] IDX_MUTE_LEVEL = 6'h14;
  localparam logic [5:0] IDX_CHAN_CTL = 6'h15;
  // Slew status fields
  localparam int SEC_RISE_BIT = 7;
  localparam int SEC_FALL_BIT = 6;
  localparam int PRI_RISE_BIT = 5;
  localparam int PRI_FALL_BIT = 4;
  localparam logic [3:0] SLEW_STATUS_RESET = 4'h0;
  // Status pin control fields
  localparam int STAT_CTL_W = 6;
  localparam int B_SPIKE_BIT = 5;
  localparam int A_SPIKE_BIT = 4;
  localparam int B_OPEN_DRAIN_BIT = 1;
  localparam int A_OPEN_DRAIN_BIT = 0;
  localparam logic [5:0] STAT_CTL_RESET = 6'h00;
  // Mute level fields
  localparam int CH3_LVL_MSB = 7;
  localparam int CH3_LVL_LSB = 6;
  localparam logic [7:0] MUTE_LEVEL_RESET = 8'h55;
  localparam logic [1:0] MUTE_LVL_BYPASS = 2'h0;
  localparam logic [1:0] MUTE_LVL_SOFT = 2'h1;
  localparam logic [1:0] MUTE_LVL_HIGH = 2'h2;
  localparam logic [1:0] MUTE_LVL_RAIL = 2'h3;
  // Channel control fields
  localparam int CHAN3_MUTE_BIT = 0;
  localparam int CHAN3_SE_BIT = 1;
  localparam logic [1:0] CHAN_CTL_RESET = 2'h0;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WR_IDLE = 2'h0,
    WR_ADDR = 2'h1,
    WR_RESP = 2'h3,
    WR_DATA = 2'h2
  } wr_state_type;

  typedef enum logic {
    RD_IDLE = 1'h0,
    RD_DATA = 1'h1
  } rd_state_type;

  typedef enum logic [2:0] {
    LEG_NORMAL = 3'h0,
    LEG_LOW = 3'h1,
    LEG_HIGH = 3'h3,
    LEG_VCM = 3'h2,
    LEG_RAIL = 3'h6
  } leg_drive_type;

  function automatic logic addr_is(input logic [ADDR_W-1:0] addr, input logic [5:0] idx);
    return addr == {idx, 2'h0};
  endfunction
endpackage
`default_nettype wire

// ### design/ref_status_and_mute_level_regs.sv
// Register bank slice: input slew status, status pin drivers, channel 3 mute level
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/100ps
`default_nettype none
module ref_status_and_mute_level_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AXI4-Lite write address
  input wire logic [clkgen_regs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [clkgen_regs_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [clkgen_regs_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [clkgen_regs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [clkgen_regs_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Slew rate detector flags, asynchronous
  input wire logic sec_in_rising_ok,
  input wire logic sec_in_falling_ok,
  input wire logic pri_in_rising_ok,
  input wire logic pri_in_falling_ok,
  // Status pin sources
  input wire logic status_a_src,
  input wire logic status_b_src,
  // Status pin A pad
  output logic status_pin_a_out,
  output logic status_pin_a_oe_n,
  output logic status_a_spike_limit,
  // Status pin B pad
  output logic status_pin_b_out,
  output logic status_pin_b_oe_n,
  output logic status_b_spike_limit,
  // Channel 3 driver
  input wire logic chan3_src_p,
  input wire logic chan3_src_n,
  output logic chan3_out_p,
  output logic chan3_out_n,
  output clkgen_regs_pkg::leg_drive_type chan3_p_drive,
  output clkgen_regs_pkg::leg_drive_type chan3_n_drive
);
  import clkgen_regs_pkg::*;

  wr_state_type wr_state_reg;
  wr_state_type wr_state_next;
  rd_state_type rd_state_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic wlane_reg;
  logic [1:0] bresp_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_commit;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_lane0;
  logic wr_mapped;
  logic [DATA_W-1:0] rd_word;
  logic rd_hit;
  logic [SEC_RISE_BIT:PRI_FALL_BIT] slew_pins;
  logic [SEC_RISE_BIT:PRI_FALL_BIT] sync1_reg;
  logic [SEC_RISE_BIT:PRI_FALL_BIT] sync2_reg;
  logic [SEC_RISE_BIT:PRI_FALL_BIT] sync3_reg;
  logic [SEC_RISE_BIT:PRI_FALL_BIT] slew_stat_reg;
  logic [SEC_RISE_BIT:PRI_FALL_BIT] slew_stat_next;
  logic [STAT_CTL_W-1:0] stat_ctl_reg;
  logic [7:0] mute_level_reg;
  logic [1:0] chan_ctl_reg;
  logic [1:0] chan3_muted_drive_sel;
  logic chan3_mute_on;

  // Write channel handshakes
  assign s_axi_awready = (wr_state_reg == WR_IDLE) || (wr_state_reg == WR_DATA);
  assign s_axi_wready = (wr_state_reg == WR_IDLE) || (wr_state_reg == WR_ADDR);
  assign s_axi_bvalid = (wr_state_reg == WR_RESP);
  assign s_axi_bresp = bresp_reg;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;

  always_comb begin
    wr_state_next = wr_state_reg;
    case (wr_state_reg)
      WR_IDLE: begin
        if (aw_take && w_take) begin
          wr_state_next = WR_RESP;
        end else if (aw_take) begin
          wr_state_next = WR_ADDR;
        end else if (w_take) begin
          wr_state_next = WR_DATA;
        end
      end
      WR_ADDR: begin
        if (w_take) begin
          wr_state_next = WR_RESP;
        end
      end
      WR_DATA: begin
        if (aw_take) begin
          wr_state_next = WR_RESP;
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          wr_state_next = WR_IDLE;
        end
      end
      default: wr_state_next = WR_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_state_reg <= WR_IDLE;
    end else begin
      wr_state_reg <= wr_state_next;
    end
  end

  // Hold whichever half arrived first
  always_ff @(posedge clk) begin
    if (!nrst) begin
      awaddr_reg <= '0;
      wdata_reg <= 8'h00;
      wlane_reg <= 1'h0;
    end else begin
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata[7:0];
        wlane_reg <= s_axi_wstrb[0];
      end
    end
  end

  assign wr_commit = (wr_state_next == WR_RESP) && (wr_state_reg != WR_RESP);
  assign wr_addr = (wr_state_reg == WR_ADDR) ? awaddr_reg : s_axi_awaddr;
  assign wr_byte = (wr_state_reg == WR_DATA) ? wdata_reg : s_axi_wdata[7:0];
  assign wr_lane0 = (wr_state_reg == WR_DATA) ? wlane_reg : s_axi_wstrb[0];
  assign wr_mapped = addr_is(wr_addr, IDX_SLEW_STATUS) || addr_is(wr_addr, IDX_STAT_PIN_CTL) ||
                     addr_is(wr_addr, IDX_MUTE_LEVEL) || addr_is(wr_addr, IDX_CHAN_CTL);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      bresp_reg <= RESP_OKAY;
    end else if (wr_commit) begin
      bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Writable registers; the slew status ignores writes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      stat_ctl_reg <= STAT_CTL_RESET;
    end else if (wr_commit && wr_lane0 && addr_is(wr_addr, IDX_STAT_PIN_CTL)) begin
      stat_ctl_reg <= wr_byte[STAT_CTL_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mute_level_reg <= MUTE_LEVEL_RESET;
    end else if (wr_commit && wr_lane0 && addr_is(wr_addr, IDX_MUTE_LEVEL)) begin
      mute_level_reg <= wr_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      chan_ctl_reg <= CHAN_CTL_RESET;
    end else if (wr_commit && wr_lane0 && addr_is(wr_addr, IDX_CHAN_CTL)) begin
      chan_ctl_reg <= wr_byte[1:0];
    end
  end

  // Read channel
  assign s_axi_arready = (rd_state_reg == RD_IDLE);
  assign s_axi_rvalid = (rd_state_reg == RD_DATA);
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_word = '0;
    rd_hit = 1'h1;
    if (addr_is(s_axi_araddr, IDX_SLEW_STATUS)) begin
      rd_word[SEC_RISE_BIT:PRI_FALL_BIT] = slew_stat_reg;
    end else if (addr_is(s_axi_araddr, IDX_STAT_PIN_CTL)) begin
      rd_word[STAT_CTL_W-1:0] = stat_ctl_reg;
    end else if (addr_is(s_axi_araddr, IDX_MUTE_LEVEL)) begin
      rd_word[7:0] = mute_level_reg;
    end else if (addr_is(s_axi_araddr, IDX_CHAN_CTL)) begin
      rd_word[1:0] = chan_ctl_reg;
    end else begin
      rd_hit = 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_state_reg <= RD_IDLE;
    end else if (ar_take) begin
      rd_state_reg <= RD_DATA;
    end else if (s_axi_rready) begin
      rd_state_reg <= RD_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (ar_take) begin
      rdata_reg <= rd_word;
      rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Slew flags cross in; a bit moves once the last two stages agree
  assign slew_pins = {sec_in_rising_ok, sec_in_falling_ok, pri_in_rising_ok, pri_in_falling_ok};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_reg <= SLEW_STATUS_RESET;
      sync2_reg <= SLEW_STATUS_RESET;
      sync3_reg <= SLEW_STATUS_RESET;
    end else begin
      sync1_reg <= slew_pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign slew_stat_next = (~(sync2_reg ^ sync3_reg) & sync3_reg) |
                          ((sync2_reg ^ sync3_reg) & slew_stat_reg);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      slew_stat_reg <= SLEW_STATUS_RESET;
    end else begin
      slew_stat_reg <= slew_stat_next;
    end
  end

  // Status pin drivers
  status_pin_drv u_status_a (
    .clk(clk),
    .nrst(nrst),
    .src(status_a_src),
    .open_drain_en(stat_ctl_reg[A_OPEN_DRAIN_BIT]),
    .spike_limit(stat_ctl_reg[A_SPIKE_BIT]),
    .pin_out(status_pin_a_out),
    .pin_oe_n(status_pin_a_oe_n),
    .pin_slow_edges(status_a_spike_limit)
  );

  status_pin_drv u_status_b (
    .clk(clk),
    .nrst(nrst),
    .src(status_b_src),
    .open_drain_en(stat_ctl_reg[B_OPEN_DRAIN_BIT]),
    .spike_limit(stat_ctl_reg[B_SPIKE_BIT]),
    .pin_out(status_pin_b_out),
    .pin_oe_n(status_pin_b_oe_n),
    .pin_slow_edges(status_b_spike_limit)
  );

  // Channel 3 driver; the level field only shapes a mute the mute bit asks for
  assign chan3_muted_drive_sel = mute_level_reg[CH3_LVL_MSB:CH3_LVL_LSB];
  assign chan3_mute_on = chan_ctl_reg[CHAN3_MUTE_BIT];

  chan_mute_drv u_chan3 (
    .clk(clk),
    .nrst(nrst),
    .mute_on(chan3_mute_on),
    .muted_drive_sel(chan3_muted_drive_sel),
    .single_ended(chan_ctl_reg[CHAN3_SE_BIT]),
    .src_p(chan3_src_p),
    .src_n(chan3_src_n),
    .out_p(chan3_out_p),
    .out_n(chan3_out_n),
    .p_drive(chan3_p_drive),
    .n_drive(chan3_n_drive)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence wr_to(logic [5:0] idx);
    wr_commit && wr_lane0 && addr_is(wr_addr, idx);
  endsequence

  sequence rd_of(logic [5:0] idx);
    ar_take && addr_is(s_axi_araddr, idx);
  endsequence

  property p_read_bit(logic [5:0] idx, int bitpos, logic src);
    rd_of(idx) |=> s_axi_rvalid &&
      (s_axi_rdata[bitpos] == $past(src));
  endproperty

  // Read data shows the register as it stood when the address was taken
  a_sec_rise_view: assert property (
    rd_of(IDX_SLEW_STATUS) |=>
      s_axi_rdata[SEC_RISE_BIT] == $past(slew_stat_reg[SEC_RISE_BIT]))
    else $error("secondary rising flag misread");
  a_sec_fall_view: assert property (
    rd_of(IDX_SLEW_STATUS) |=>
      s_axi_rdata[SEC_FALL_BIT] == $past(slew_stat_reg[SEC_FALL_BIT]))
    else $error("secondary falling flag misread");
  a_pri_flag_view: assert property (
    rd_of(IDX_SLEW_STATUS) |=> (s_axi_rdata[5:4] == $past(slew_stat_reg[5:4])) &&
      (s_axi_rdata[3:0] == 4'h0))
    else $error("primary flags misread");
  a_slew_settle: assert property (
    (sync2_reg == sync3_reg) ##1 (sync2_reg == sync3_reg) |=> slew_stat_reg == $past(sync3_reg))
    else $error("settled flags not shown");
  a_stat_b_od: assert property (
    wr_to(IDX_STAT_PIN_CTL) |=>
      stat_ctl_reg[B_OPEN_DRAIN_BIT] == $past(wr_byte[B_OPEN_DRAIN_BIT]))
    else $error("pin B open drain not stored");
  // The pad follows one edge after the control bit lands
  a_stat_a_od: assert property (
    wr_to(IDX_STAT_PIN_CTL) ##0 wr_byte[A_OPEN_DRAIN_BIT] |=> ##1 !status_pin_a_out)
    else $error("pin A open drain not applied");
  a_spike_limit_rd: assert property (
    p_read_bit(IDX_STAT_PIN_CTL, B_SPIKE_BIT, stat_ctl_reg[B_SPIKE_BIT]))
    else $error("spike limit readback wrong");
  a_ch3_level_write: assert property (
    wr_to(IDX_MUTE_LEVEL) |=>
      chan3_muted_drive_sel == $past(wr_byte[CH3_LVL_MSB:CH3_LVL_LSB]))
    else $error("channel 3 level not stored");
endmodule // ref_status_and_mute_level_regs
`default_nettype wire

// ### design/status_pin_drv.sv
// Status pin driver: push-pull or open drain with edge limiting control
`timescale 1ns/100ps
`default_nettype none
module status_pin_drv (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic src,
  input wire logic open_drain_en,
  input wire logic spike_limit,
  // Pad
  output logic pin_out,
  output logic pin_oe_n,
  output logic pin_slow_edges
);
  import clkgen_regs_pkg::*;

  // Open drain only pulls low; a high level releases the pad
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_out <= 1'h0;
      pin_oe_n <= 1'h1;
    end else if (open_drain_en) begin
      pin_out <= 1'h0;
      pin_oe_n <= src;
    end else begin
      pin_out <= src;
      pin_oe_n <= 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_slow_edges <= 1'h0;
    end else begin
      pin_slow_edges <= spike_limit;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_open_drain_pull: assert property (
    nrst && open_drain_en |=> (pin_out == 1'h0) && (pin_oe_n == $past(src)))
    else $error("open drain pad not low or enable wrong");
  a_push_pull_drive: assert property (
    nrst && !open_drain_en ##1 !open_drain_en |-> !pin_oe_n && (pin_out == $past(src)))
    else $error("push-pull pad not driving source");
  a_spike_follow: assert property (
    nrst && $changed(spike_limit) |=> pin_slow_edges == $past(spike_limit))
    else $error("spike limit not passed to pad");
endmodule // status_pin_drv
`default_nettype wire

// ### sim/ref_status_and_mute_level_regs_test.sv
// Self-checking bench for the reference status and mute level register slice
`timescale 1ns/100ps
`default_nettype none
module ref_status_and_mute_level_regs_test;
  import clkgen_regs_pkg::*;
  typedef struct {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [1:0] resp;
    logic [31:0] rdata;
  } row_type;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [3:0] slew = 4'h0;
  logic src_a = 1'b0;
  logic src_b = 1'b0;
  logic src_p = 1'b0;
  logic src_n = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, data;
  logic a_out, a_oe_n, a_lim, b_out, b_oe_n, b_lim, c_out_p, c_out_n;
  leg_drive_type p_drv, n_drv;
  int failures = 0;
  int tests_run = 0;
  row_type rows [6];

  always begin
    #12.5 clk = ~clk;
  end

  ref_status_and_mute_level_regs ref_status_and_mute_level_regs_i (
    .clk(clk), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sec_in_rising_ok(slew[3]), .sec_in_falling_ok(slew[2]),
    .pri_in_rising_ok(slew[1]), .pri_in_falling_ok(slew[0]),
    .status_a_src(src_a), .status_b_src(src_b),
    .status_pin_a_out(a_out), .status_pin_a_oe_n(a_oe_n), .status_a_spike_limit(a_lim),
    .status_pin_b_out(b_out), .status_pin_b_oe_n(b_oe_n), .status_b_spike_limit(b_lim),
    .chan3_src_p(src_p), .chan3_src_n(src_n), .chan3_out_p(c_out_p), .chan3_out_n(c_out_n),
    .chan3_p_drive(p_drv), .chan3_n_drive(n_drv)
  );

  task automatic complete_run();
    $display("Counts: %0d checks, %0d mismatches", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic timed_out();
    failures++;
    $display("[ERR] bus handshake expected answer seen timeout");
    complete_run();
  endtask

  // Master holds each channel until its own ready is sampled high
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    n = 0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (n > 50) timed_out();
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_check(input string name, input logic [7:0] a, input logic [31:0] exp,
                          input logic [1:0] er);
    int n;
    @(posedge clk);
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (n > 50) timed_out();
    end while (!rvalid);
    data = rdata;
    resp = rresp;
    rready <= 1'b0;
    check(name, exp, data);
    check("read resp", {30'h0, er}, {30'h0, resp});
  endtask

  task automatic pad_check(input logic [7:0] ctl, input logic [1:0] src, input logic [5:0] e);
    src_a <= src[0];
    src_b <= src[1];
    bus_write(8'h4C, ctl);
    repeat (2) @(posedge clk);
    check("status pads", {26'h0, e}, {26'h0, a_out, a_oe_n, a_lim, b_out, b_oe_n, b_lim});
  endtask

  function automatic logic [5:0] exp_drive(input logic se, input logic [1:0] code,
                                           input logic mute);
    if (!mute || code == MUTE_LVL_BYPASS) return {LEG_NORMAL, LEG_NORMAL};
    case ({se, code})
      3'b001: return {LEG_VCM, LEG_VCM};
      3'b010: return {LEG_HIGH, LEG_LOW};
      3'b011: return {LEG_RAIL, LEG_LOW};
      3'b101: return {LEG_NORMAL, LEG_LOW};
      3'b110: return {LEG_LOW, LEG_NORMAL};
      default: return {LEG_LOW, LEG_LOW};
    endcase
  endfunction

  initial begin
    rows[0] = '{8'h4C, 8'h33, RESP_OKAY, 32'h00000033};
    rows[1] = '{8'h4C, 8'hC2, RESP_OKAY, 32'h00000002};
    rows[2] = '{8'h50, 8'hC0, RESP_OKAY, 32'h000000C0};
    rows[3] = '{8'h50, 8'h9B, RESP_OKAY, 32'h0000009B};
    rows[4] = '{8'h48, 8'hF0, RESP_OKAY, 32'h00000000};
    rows[5] = '{8'h5C, 8'h12, RESP_SLVERR, 32'h00000000};
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      bus_write(rows[i].addr, rows[i].wdata);
      check("write resp", {30'h0, rows[i].resp}, {30'h0, resp});
      rd_check("row read", rows[i].addr, rows[i].rdata, rows[i].resp);
      $display("Row %0d done", i);
    end
    slew <= 4'hA;
    repeat (6) @(posedge clk);
    rd_check("slew status", 8'h48, 32'h000000A0, RESP_OKAY);
    slew <= 4'h5;
    repeat (6) @(posedge clk);
    rd_check("slew status", 8'h48, 32'h00000050, RESP_OKAY);
    $display("Slew status test done");
    pad_check(8'h00, 2'b01, 6'h20);
    pad_check(8'h33, 2'b01, 6'h19);
    pad_check(8'h02, 2'b11, 6'h22);
    $display("Status pad test done");
    src_p <= 1'b1;
    for (int m = 0; m < 16; m++) begin
      bus_write(8'h50, {m[1:0], 6'h3F});
      bus_write(8'h54, {6'h00, m[2], ~m[3]});
      repeat (2) @(posedge clk);
      check("chan3 drive", {26'h0, exp_drive(m[2], m[1:0], !m[3])}, {26'h0, p_drv, n_drv});
    end
    check("chan3 legs", 32'h00000002, {30'h0, c_out_p, c_out_n});
    $display("Channel 3 mute test done");
    slew <= 4'h0;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    check("pads in reset", 32'h00000012, {26'h0, a_out, a_oe_n, a_lim, b_out, b_oe_n, b_lim});
    nrst <= 1'b1;
    rd_check("ctl reset", 8'h4C, 32'h00000000, RESP_OKAY);
    rd_check("mute reset", 8'h50, 32'h00000055, RESP_OKAY);
    rd_check("slew reset", 8'h48, 32'h00000000, RESP_OKAY);
    $display("Reset test done");
    complete_run();
  end
endmodule // ref_status_and_mute_level_regs_test
`default_nettype wire
